// *** hw/plb_pkg.sv ***
// Constants and types shared by the programmable logic block.
package plb_pkg;
  localparam int AXI_ADDR_W = 16;
  localparam int BUS_W = 61;
  localparam int NUM_SELECTS = 8;
  localparam int NUM_CELLS = 8;
  localparam int PA_TERMS = 6;
  localparam int PB_TERMS = 10;
  // Input bus bit positions
  localparam int BUS_PA = 0;
  localparam int BUS_PB = 8;
  localparam int BUS_PE = 16;
  localparam int BUS_PC = 24;
  localparam int BUS_PD = 32;
  localparam int BUS_PGR = 40;
  localparam int BUS_WDOG = 44;
  localparam int BUS_INTR = 45;
  localparam int BUS_AHI = 46;
  localparam int BUS_A0 = 54;
  localparam int BUS_A1 = 55;
  localparam int BUS_RD = 56;
  localparam int BUS_WR = 57;
  localparam int BUS_INPUT_CLOCK_PIN = 58;
  localparam int BUS_RESET = 59;
  localparam int BUS_CSI = 60;
  // Product term numbering
  localparam int T_DEC = 0;
  localparam int T_PORT_A_GROUP_OUTPUT_ENABLE_TERM = 8;
  localparam int T_PORT_A_GROUP_PRESET_TERM = 9;
  localparam int T_PA_CLR = 10;
  localparam int T_PA_CELL = 11;
  localparam int T_PB_CELL = 59;
  localparam int T_PB_PR = 139;
  localparam int T_PB_CLR = 147;
  localparam int T_PB_CLK = 155;
  localparam int T_PB_OE = 163;
  localparam int NUM_TERMS = 171;
  localparam int TERM_WORDS = NUM_TERMS * 4;
  localparam int TERM_IDX_W = 10;
  // Decode select positions
  localparam int SEL_MEM = 0;
  localparam int SEL_SRAM = 4;
  localparam int SEL_IO = 5;
  localparam int SEL_PERIPH = 6;
  // Register offsets
  localparam logic [AXI_ADDR_W-1:0] OFS_PA_CFG = 16'h0000;
  localparam logic [AXI_ADDR_W-1:0] OFS_PA_MODE = 16'h0004;
  localparam logic [AXI_ADDR_W-1:0] OFS_PB_CFG = 16'h0008;
  localparam logic [AXI_ADDR_W-1:0] OFS_PB_MODE = 16'h000C;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 16'h0010;
  localparam logic [AXI_ADDR_W-1:0] OFS_TERM_BASE = 16'h1000;
  localparam logic [AXI_ADDR_W-1:0] OFS_TERM_END = OFS_TERM_BASE + 16'(TERM_WORDS * 4);
  // Field layout of the cell configuration words
  localparam int CFG_POL = 0;
  localparam int CFG_REGSEL = 8;
  localparam int CFG_FBCOMB = 16;
  localparam int CFG_BURIED = 24;
  localparam int MODE_RST_EN = 16;
  localparam int MODE_CLR_TERM = 16;
  localparam int MODE_CLK_TERM = 24;
  localparam logic [31:0] PA_MODE_MASK = 32'h0001_FFFF;
  localparam logic [31:0] TERM_HI_MASK = 32'h1FFF_FFFF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PIN_IN = 2'h0,
    PIN_OUT = 2'h1,
    PIN_BIDIR = 2'h3
  } plb_pin_mode_t;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } plb_wr_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } plb_rd_t;
endpackage : plb_pkg

// *** hw/plb_top.sv ***
// Programmable decode array and port A/B logic cells with AXI4-Lite setup.
`timescale 1ns/1ps
module plb_top
  import plb_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [AXI_ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [AXI_ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic [7:0] addr_lo,
  input logic [7:0] addr_hi,
  input logic rd_strobe,
  input logic wr_strobe,
  input logic input_clock_pin,
  input logic reset_pin_n,
  input logic chip_select_pin,
  input logic power_down,
  input logic [3:0] page_register_bits,
  input logic timer_watchdog_to_logic,
  input logic interrupt_to_logic,
  input logic [7:0] pc_in,
  input logic [7:0] pd_in,
  input logic [7:0] pe_in,
  input logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] port_a_group_output_enable_term,
  input logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [3:0] memory_block_selects,
  output logic static_ram_block_select,
  output logic io_decoder_select,
  output logic [1:0] peripheral_mode_selects,
  output logic io_register_hit,
  output logic [7:0] io_register_index
);
  typedef struct packed {
    logic [31:0] pa_cfg;
    logic [31:0] pa_mode;
    logic [31:0] pb_cfg;
    logic [31:0] pb_mode;
    logic [7:0] ff_a;
    logic [7:0] ff_b;
    logic [7:0] or_a_q;
    logic [7:0] or_b_q;
    logic [7:0] pbclk_prev;
    logic clk_prev;
    logic [NUM_SELECTS-1:0] sel;
    logic io_hit;
    logic [7:0] io_idx;
    logic [7:0] pa_out;
    logic [7:0] port_a_group_output_enable_term;
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    plb_wr_t wst;
    logic aw_held;
    logic w_held;
    logic [AXI_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp;
    plb_rd_t rst;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } plb_state_t;
  plb_state_t st;
  plb_state_t next_st;
  logic [31:0] term_mem [0:TERM_WORDS-1];
  logic mem_we;
  logic [TERM_IDX_W-1:0] mem_idx;
  logic [31:0] mem_wdata;
  logic [BUS_W-1:0] bus;
  logic [NUM_TERMS-1:0] terms;
  logic [7:0] or_a;
  logic [7:0] or_b;
  logic [7:0] pb_clr;
  logic [7:0] pb_edge;
  logic input_clock_pin_rise;
  logic cell_reset;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge
  function automatic logic is_term(input logic [AXI_ADDR_W-1:0] a);
    return (a >= OFS_TERM_BASE) && (a < OFS_TERM_END);
  endfunction : is_term
  function automatic logic [TERM_IDX_W-1:0] term_idx(input logic [AXI_ADDR_W-1:0] a);
    logic [AXI_ADDR_W-1:0] d;
    d = a - OFS_TERM_BASE;
    return d[TERM_IDX_W+1:2];
  endfunction : term_idx
  always_comb begin
    bus = '0;
    for (int c = 0; c < NUM_CELLS; c++) begin
      // pin replaces feedback in input mode and in bidirectional mode when not buried
      if (st.pa_mode[2*c +: 2] == PIN_IN ||
          (st.pa_mode[2*c +: 2] == PIN_BIDIR && !st.pa_cfg[CFG_BURIED+c])) begin
        bus[BUS_PA+c] = pa_in[c];
      end else begin
        bus[BUS_PA+c] = st.pa_cfg[CFG_FBCOMB+c] ? st.or_a_q[c] : st.ff_a[c];
      end
      if (st.pb_mode[2*c +: 2] == PIN_IN ||
          (st.pb_mode[2*c +: 2] == PIN_BIDIR && !st.pb_cfg[CFG_BURIED+c])) begin
        bus[BUS_PB+c] = pb_in[c];
      end else begin
        bus[BUS_PB+c] = st.pb_cfg[CFG_FBCOMB+c] ? st.or_b_q[c] : st.ff_b[c];
      end
    end
    bus[BUS_PE +: 8] = pe_in;
    bus[BUS_PC +: 8] = pc_in;
    bus[BUS_PD +: 8] = pd_in;
    bus[BUS_PGR +: 4] = page_register_bits;
    bus[BUS_WDOG] = timer_watchdog_to_logic;
    bus[BUS_INTR] = interrupt_to_logic;
    bus[BUS_AHI +: 8] = addr_hi;
    bus[BUS_A0] = addr_lo[0];
    bus[BUS_A1] = addr_lo[1];
    bus[BUS_RD] = rd_strobe;
    bus[BUS_WR] = wr_strobe;
    bus[BUS_INPUT_CLOCK_PIN] = input_clock_pin;
    bus[BUS_RESET] = reset_pin_n;
    bus[BUS_CSI] = chip_select_pin | power_down;
  end
  always_comb begin
    logic [BUS_W-1:0] tru;
    logic [BUS_W-1:0] cmp;
    tru = '0;
    cmp = '0;
    for (int t = 0; t < NUM_TERMS; t++) begin
      tru = {term_mem[4*t+1][BUS_W-33:0], term_mem[4*t]};
      cmp = {term_mem[4*t+3][BUS_W-33:0], term_mem[4*t+2]};
      // an empty term stays low, so undefined presets never fire
      terms[t] = (|(tru | cmp)) & (&(~tru | bus)) & (&(~cmp | ~bus));
    end
  end
  always_comb begin
    for (int c = 0; c < NUM_CELLS; c++) begin
      // six-term OR per port A cell
      or_a[c] = |terms[T_PA_CELL + c*PA_TERMS +: PA_TERMS];
      // ten-term OR per port B cell
      or_b[c] = |terms[T_PB_CELL + c*PB_TERMS +: PB_TERMS];
      pb_clr[c] = st.pb_mode[MODE_CLR_TERM+c] ? terms[T_PB_CLR+c] : !reset_pin_n;
      pb_edge[c] = st.pb_mode[MODE_CLK_TERM+c] ? (terms[T_PB_CLK+c] & !st.pbclk_prev[c])
                                               : input_clock_pin_rise;
    end
  end
  // Pin clock edges seen through aclk; faster pin clocks are not followed
  assign input_clock_pin_rise = input_clock_pin & !st.clk_prev;
  // configurable cell reset follows the reset pin
  assign cell_reset = st.pa_mode[MODE_RST_EN] & !reset_pin_n;
  always_comb begin
    logic [31:0] rd;
    logic [1:0] rr;
    logic [AXI_ADDR_W-1:0] wa;
    next_st = st;
    mem_we = 1'b0;
    mem_idx = '0;
    mem_wdata = '0;
    rd = '0;
    rr = RESP_OKAY;
    wa = '0;
    next_st.clk_prev = input_clock_pin;
    next_st.pbclk_prev = terms[T_PB_CLK +: NUM_CELLS];
    next_st.or_a_q = or_a;
    next_st.or_b_q = or_b;
    next_st.sel = terms[T_DEC +: NUM_SELECTS];
    // I/O decoder on low address byte
    next_st.io_hit = terms[T_DEC+SEL_IO];
    next_st.io_idx = terms[T_DEC+SEL_IO] ? addr_lo : 8'h00;
    for (int c = 0; c < NUM_CELLS; c++) begin
      // input clock drives port A cells
      if (terms[T_PA_CLR] || cell_reset) begin
        next_st.ff_a[c] = 1'b0;
      end else if (terms[T_PORT_A_GROUP_PRESET_TERM]) begin
        next_st.ff_a[c] = 1'b1;
      end else if (input_clock_pin_rise) begin
        next_st.ff_a[c] = or_a[c];
      end
      if (pb_clr[c]) begin
        next_st.ff_b[c] = 1'b0;
      end else if (terms[T_PB_PR+c]) begin
        next_st.ff_b[c] = 1'b1;
      end else if (pb_edge[c]) begin
        next_st.ff_b[c] = or_b[c];
      end
      next_st.pa_out[c] = (st.pa_cfg[CFG_REGSEL+c] ? st.ff_a[c] : or_a[c]) ^ st.pa_cfg[CFG_POL+c];
      next_st.pb_out[c] = (st.pb_cfg[CFG_REGSEL+c] ? st.ff_b[c] : or_b[c]) ^ st.pb_cfg[CFG_POL+c];
      // output buffer enable from a term
      // shared enable term for port A
      next_st.port_a_group_output_enable_term[c] = (st.pa_mode[2*c +: 2] != PIN_IN) && !st.pa_cfg[CFG_BURIED+c]
                         && terms[T_PORT_A_GROUP_OUTPUT_ENABLE_TERM];
      next_st.pb_oe[c] = (st.pb_mode[2*c +: 2] != PIN_IN) && !st.pb_cfg[CFG_BURIED+c]
                         && terms[T_PB_OE+c];
    end
    // Write channel: address and data may arrive in either order
    if (awvalid && awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata_q = wdata;
      next_st.wstrb_q = wstrb;
    end
    case (st.wst)
      WR_IDLE: begin
        if (st.aw_held && st.w_held) begin
          wa = {st.awaddr_q[AXI_ADDR_W-1:2], 2'h0};
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
          next_st.wst = WR_RESP;
          next_st.bresp = RESP_OKAY;
          if (wa == OFS_PA_CFG) begin
            next_st.pa_cfg = merge(st.pa_cfg, st.wdata_q, st.wstrb_q);
          end else if (wa == OFS_PA_MODE) begin
            next_st.pa_mode = merge(st.pa_mode, st.wdata_q, st.wstrb_q) & PA_MODE_MASK;
          end else if (wa == OFS_PB_CFG) begin
            next_st.pb_cfg = merge(st.pb_cfg, st.wdata_q, st.wstrb_q);
          end else if (wa == OFS_PB_MODE) begin
            next_st.pb_mode = merge(st.pb_mode, st.wdata_q, st.wstrb_q);
          end else if (is_term(wa)) begin
            mem_we = 1'b1;
            mem_idx = term_idx(wa);
            mem_wdata = merge(term_mem[term_idx(wa)], st.wdata_q, st.wstrb_q);
            mem_wdata = mem_wdata & (mem_idx[0] ? TERM_HI_MASK : 32'hFFFF_FFFF);
          end else if (wa != OFS_STATUS) begin
            next_st.bresp = RESP_SLVERR;
          end
        end
      end
      WR_RESP: next_st.wst = bready ? WR_IDLE : WR_RESP;
      default: next_st.wst = WR_IDLE;
    endcase
    case (st.rst)
      RD_IDLE: begin
        if (arvalid) begin
          wa = {araddr[AXI_ADDR_W-1:2], 2'h0};
          if (wa == OFS_PA_CFG) begin
            rd = st.pa_cfg;
          end else if (wa == OFS_PA_MODE) begin
            rd = st.pa_mode;
          end else if (wa == OFS_PB_CFG) begin
            rd = st.pb_cfg;
          end else if (wa == OFS_PB_MODE) begin
            rd = st.pb_mode;
          end else if (wa == OFS_STATUS) begin
            rd = {8'h00, st.ff_b, st.ff_a, st.sel};
          end else if (is_term(wa)) begin
            rd = term_mem[term_idx(wa)];
          end else begin
            rr = RESP_SLVERR;
          end
          next_st.rdata = rd;
          next_st.rresp = rr;
          next_st.rst = RD_DATA;
        end
      end
      RD_DATA: next_st.rst = rready ? RD_IDLE : RD_DATA;
      default: next_st.rst = RD_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // Reset clears all terms so no select or pin drive fires before setup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < TERM_WORDS; i++) begin
        term_mem[i] <= CFG_RESET;
      end
    end else if (mem_we) begin
      term_mem[mem_idx] <= mem_wdata;
    end
  end
  assign awready = !st.aw_held && (st.wst == WR_IDLE);
  assign wready = !st.w_held && (st.wst == WR_IDLE);
  assign bvalid = (st.wst == WR_RESP);
  assign bresp = st.bresp;
  assign arready = (st.rst == RD_IDLE);
  assign rvalid = (st.rst == RD_DATA);
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign pa_out = st.pa_out;
  assign port_a_group_output_enable_term = st.port_a_group_output_enable_term;
  assign pb_out = st.pb_out;
  assign pb_oe = st.pb_oe;
  assign memory_block_selects = st.sel[SEL_MEM +: 4];
  assign static_ram_block_select = st.sel[SEL_SRAM];
  assign io_decoder_select = st.sel[SEL_IO];
  assign peripheral_mode_selects = st.sel[SEL_PERIPH +: 2];
  assign io_register_hit = st.io_hit;
  assign io_register_index = st.io_idx;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bus_csi_a: assert property (bus[BUS_CSI] == (chip_select_pin | power_down))
    else $error("chip select bus bit wrong");
  dec_sel_a: assert property ($past(aresetn) |->
    {peripheral_mode_selects, io_decoder_select, static_ram_block_select,
     memory_block_selects} == $past(terms[T_DEC +: NUM_SELECTS]))
    else $error("decode selects do not follow terms");
  io_index_a: assert property ($past(aresetn) && $past(terms[T_DEC+SEL_IO]) |->
    io_register_hit && io_register_index == $past(addr_lo))
    else $error("io decoder index wrong");
  pin_input_a: assert property (st.pa_mode[1:0] == PIN_IN |->
    bus[BUS_PA] == pa_in[0] ##1 !port_a_group_output_enable_term[0])
    else $error("input pin not on bus or driven");
  polarity_a: assert property ($past(aresetn) && $past(st.pa_cfg[CFG_POL]) &&
    !$past(st.pa_cfg[CFG_REGSEL]) |-> pa_out[0] == !$past(or_a[0]))
    else $error("inverted polarity wrong");
  a_clear_a: assert property ($past(aresetn) && $past(terms[T_PA_CLR]) |->
    st.ff_a == 8'h00)
    else $error("group clear ignored");
  a_clock_a: assert property ($past(aresetn) && $past(input_clock_pin_rise) &&
    !$past(terms[T_PA_CLR] | terms[T_PORT_A_GROUP_PRESET_TERM] | cell_reset) |-> st.ff_a == $past(or_a))
    else $error("port A cells missed clock");
  b_preset_a: assert property ($past(aresetn) && $past(terms[T_PB_PR]) &&
    !$past(pb_clr[0]) |-> st.ff_b[0])
    else $error("port B preset ignored");
  b_hold_a: assert property ($past(aresetn) && !$past(pb_edge[0]) &&
    !$past(pb_clr[0] | terms[T_PB_PR]) |-> $stable(st.ff_b[0]))
    else $error("port B cell changed without clock");
  axi_bresp_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  dec_fire_c: cover property (io_decoder_select && io_register_hit);
  term_clk_c: cover property (st.pb_mode[MODE_CLK_TERM] && pb_edge[0]);
  axi_write_c: cover property (bvalid && bready);
  axi_read_c: cover property (rvalid && rready);
endmodule : plb_top

// *** bench/plb_host_model.sv ***
// Host address bus and port pin model facing the logic block.
`timescale 1ns/1ps
module plb_host_model (
  input logic aclk,
  input logic [7:0] pa_out,
  input logic [7:0] port_a_group_output_enable_term,
  input logic [7:0] pb_out,
  input logic [7:0] pb_oe,
  output logic [7:0] addr_lo,
  output logic [7:0] addr_hi,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic chip_select_pin,
  output logic power_down,
  output logic [7:0] pc_in,
  output logic [7:0] pa_in,
  output logic [7:0] pb_in
);
  logic [7:0] ext_a;
  logic [7:0] ext_b;
  initial begin
    addr_lo = 8'h00;
    addr_hi = 8'h00;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    chip_select_pin = 1'b0;
    power_down = 1'b0;
    pc_in = 8'h00;
    ext_a = 8'h00;
    ext_b = 8'h00;
  end
  // upper byte and A1..A0 go straight in
  task automatic drive(input logic [7:0] ah, input logic [7:0] al, input logic cs,
                       input logic pd, input logic [7:0] pc);
    @(posedge aclk);
    addr_hi <= ah;
    addr_lo <= al;
    chip_select_pin <= cs;
    power_down <= pd;
    rd_strobe <= cs;
    pc_in <= pc;
  endtask : drive
  task automatic pins(input logic [7:0] ea);
    @(posedge aclk);
    ext_a <= ea;
  endtask : pins
  // Pin level follows whichever side drives it
  assign pa_in = (port_a_group_output_enable_term & pa_out) | (~port_a_group_output_enable_term & ext_a);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule : plb_host_model

// *** bench/tb_top.sv ***
// Self-checking bench for the programmable logic block.
`timescale 1ns/1ps
module tb_top
  import plb_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] addr_lo, addr_hi, pc_in, pa_in, pb_in, pa_out, port_a_group_output_enable_term, pb_out, pb_oe;
  logic rd_strobe, wr_strobe, chip_select_pin, power_down;
  logic input_clock_pin = 1'b0;
  logic reset_pin_n = 1'b1;
  // Sources outside this block; page bits and watchdog are stepped
  logic [3:0] page_register_bits = 4'h0;
  logic timer_watchdog_to_logic = 1'b0;
  logic interrupt_to_logic = 1'b0;
  logic [7:0] pd_in = 8'h00;
  logic [7:0] pe_in = 8'h00;
  logic [3:0] memory_block_selects;
  logic static_ram_block_select, io_decoder_select, io_register_hit;
  logic [1:0] peripheral_mode_selects;
  logic [7:0] io_register_index, sels;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  assign sels = {peripheral_mode_selects, io_decoder_select, static_ram_block_select,
                 memory_block_selects};
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end

  plb_top plb_top_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .addr_lo(addr_lo),
    .addr_hi(addr_hi), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .input_clock_pin(input_clock_pin), .reset_pin_n(reset_pin_n),
    .chip_select_pin(chip_select_pin), .power_down(power_down),
    .page_register_bits(page_register_bits),
    .timer_watchdog_to_logic(timer_watchdog_to_logic),
    .interrupt_to_logic(interrupt_to_logic), .pc_in(pc_in), .pd_in(pd_in), .pe_in(pe_in),
    .pa_in(pa_in), .pa_out(pa_out), .port_a_group_output_enable_term(port_a_group_output_enable_term), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .memory_block_selects(memory_block_selects),
    .static_ram_block_select(static_ram_block_select), .io_decoder_select(io_decoder_select),
    .peripheral_mode_selects(peripheral_mode_selects), .io_register_hit(io_register_hit),
    .io_register_index(io_register_index)
  );
  plb_host_model plb_host_model_i (
    .aclk(aclk), .pa_out(pa_out), .port_a_group_output_enable_term(port_a_group_output_enable_term), .pb_out(pb_out), .pb_oe(pb_oe),
    .addr_lo(addr_lo), .addr_hi(addr_hi), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .chip_select_pin(chip_select_pin), .power_down(power_down), .pc_in(pc_in),
    .pa_in(pa_in), .pb_in(pb_in)
  );

  always #5 aclk = ~aclk;

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Hang guard well above the expected run length
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : wr

  // Term t, word w: true masks in words 0-1, complement masks in 2-3
  task automatic tw(input int t, input int w, input logic [31:0] d);
    wr(OFS_TERM_BASE + 16'(t * 16 + w * 4), d);
  endtask : tw

  function automatic logic [31:0] bt(input int b);
    return 32'h0000_0001 << (b % 32);
  endfunction : bt

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(OFS_PA_CFG, d, r);
    `CHK("pa_cfg reset", CFG_RESET, d)
    wr(OFS_PA_CFG, 32'h0000_00A5);
    axi_rd(OFS_PA_CFG, d, r);
    `CHK("pa_cfg back", 32'h0000_00A5, d)
    wr(OFS_PA_CFG, 32'h0000_0000);
    axi_wr(16'h0020, 32'h0000_0001, r);
    `CHK("hole bresp", RESP_SLVERR, r)
    axi_rd(16'h0020, d, r);
    `CHK("hole rresp", RESP_SLVERR, r)
  endtask : t_regs

  // One address bit per select, each select alone
  task automatic t_decode();
    for (int k = 0; k < 8; k++) tw(k, 1, bt(BUS_AHI + k));
    for (int k = 0; k < 8; k++) begin
      plb_host_model_i.drive(8'h01 << k, 8'h5A, 1'b0, 1'b0, 8'h00);
      settle(2);
      `CHK("selects", 8'h01 << k, sels)
      `CHK("io hit", k == 5, io_register_hit)
      `CHK("io index", (k == 5) ? 8'h5A : 8'h00, io_register_index)
    end
  endtask : t_decode

  task automatic t_terms();
    tw(0, 1, bt(BUS_AHI + 1));
    tw(0, 3, bt(BUS_AHI));
    plb_host_model_i.drive(8'h02, 8'h00, 1'b0, 1'b0, 8'h00);
    settle(2);
    `CHK("cmp true", 1'b1, sels[0])
    plb_host_model_i.drive(8'h03, 8'h00, 1'b0, 1'b0, 8'h00);
    settle(2);
    `CHK("cmp false", 1'b0, sels[0])
    tw(7, 1, bt(BUS_CSI));
    plb_host_model_i.drive(8'h00, 8'h00, 1'b0, 1'b1, 8'h00);
    settle(2);
    `CHK("cs by pd", 1'b1, sels[7])
    plb_host_model_i.drive(8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
    settle(2);
    `CHK("cs idle", 1'b0, sels[7])
    tw(6, 1, bt(BUS_PGR));
    tw(4, 1, bt(BUS_WDOG));
    @(posedge aclk);
    page_register_bits <= 4'h1;
    timer_watchdog_to_logic <= 1'b1;
    settle(2);
    `CHK("page term", 1'b1, sels[6])
    `CHK("watchdog term", 1'b1, sels[4])
    @(posedge aclk);
    page_register_bits <= 4'h0;
    timer_watchdog_to_logic <= 1'b0;
    settle(2);
    `CHK("page idle", 1'b0, sels[6])
    `CHK("watchdog idle", 1'b0, sels[4])
  endtask : t_terms

  task automatic t_pa();
    tw(8, 1, bt(BUS_CSI));
    tw(11, 0, bt(BUS_PC));
    wr(OFS_PA_MODE, 32'h0000_0001);
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h01);
    settle(2);
    `CHK("port_a_group_output_enable_term", 1'b1, port_a_group_output_enable_term[0])
    `CHK("pa comb", 1'b1, pa_out[0])
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
    wr(OFS_PA_CFG, 32'h0000_0001);
    settle(2);
    `CHK("pa invert", 1'b1, pa_out[0])
    wr(OFS_PA_CFG, 32'h0000_0100);
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h01);
    settle(3);
    `CHK("pa unclocked", 1'b0, pa_out[0])
    @(posedge aclk);
    input_clock_pin <= 1'b1;
    settle(3);
    `CHK("pa clocked", 1'b1, pa_out[0])
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
    settle(3);
    `CHK("pa held", 1'b1, pa_out[0])
    wr(OFS_PA_MODE, 32'h0001_0001);
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    settle(3);
    `CHK("pa pin clear", 1'b0, pa_out[0])
    @(posedge aclk);
    reset_pin_n <= 1'b1;
    tw(9, 0, bt(BUS_PC + 1));
    tw(10, 0, bt(BUS_PC + 2));
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h02);
    settle(3);
    `CHK("pa preset", 1'b1, pa_out[0])
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h06);
    settle(3);
    `CHK("pa clear", 1'b0, pa_out[0])
    wr(OFS_PA_CFG, 32'h0100_0100);
    tw(2, 1, 32'h0000_0000);
    tw(2, 0, bt(BUS_PA));
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h02);
    settle(4);
    `CHK("pa buried", 1'b0, port_a_group_output_enable_term[0])
    `CHK("pa feedback", 1'b1, sels[2])
    // Cell 1 is an input, so its pin reaches the bus
    tw(1, 1, 32'h0000_0000);
    tw(1, 0, bt(BUS_PA + 1));
    plb_host_model_i.pins(8'h02);
    settle(2);
    `CHK("pa pin in", 1'b1, sels[1])
    plb_host_model_i.pins(8'h00);
    settle(2);
    `CHK("pa pin low", 1'b0, sels[1])
  endtask : t_pa

  task automatic t_pb();
    wr(OFS_PB_MODE, 32'h0100_0001);
    wr(OFS_PB_CFG, 32'h0000_0100);
    tw(163, 1, bt(BUS_CSI));
    tw(59, 0, bt(BUS_PC));
    tw(155, 0, bt(BUS_PC + 3));
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h01);
    settle(3);
    `CHK("pb idle", 1'b0, pb_out[0])
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h09);
    settle(3);
    `CHK("pb term clock", 1'b1, pb_out[0])
    `CHK("pb oe", 1'b1, pb_oe[0])
    wr(OFS_PB_MODE, 32'h0101_0001);
    tw(147, 0, bt(BUS_PC + 4));
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h19);
    settle(3);
    `CHK("pb term clear", 1'b0, pb_out[0])
    // Clear back on the reset pin; preset term on pc5
    wr(OFS_PB_MODE, 32'h0100_0001);
    tw(139, 0, bt(BUS_PC + 5));
    plb_host_model_i.drive(8'h00, 8'h00, 1'b1, 1'b0, 8'h21);
    settle(3);
    `CHK("pb preset", 1'b1, pb_out[0])
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    settle(3);
    `CHK("pb pin clear", 1'b0, pb_out[0])
    @(posedge aclk);
    reset_pin_n <= 1'b1;
  endtask : t_pb

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_decode();
    t_terms();
    t_pa();
    t_pb();
    conclude();
  end
endmodule : tb_top
